/* core/dcr_pkg.sv */
package dcr_pkg;
    localparam int          FRAME_BITS = 24;
    localparam int          NCH        = 4;
    localparam int          DW         = 14;
    localparam int          RW_POS     = 23;
    localparam int          ADDR_LO    = 16;
    localparam int          DATA_LO    = 2;
    localparam logic [3:0]  ADDR_CMD   = 4'h0;
    localparam logic [1:0]  ADDR_DGRP  = 2'h1;
    localparam logic [15:0] CMD_RST    = 16'h033c;
    localparam int          B_AB       = 15;
    localparam int          B_LD       = 14;
    localparam int          B_RST      = 13;
    localparam int          B_PDA      = 12;
    localparam int          B_PDB      = 11;
    localparam int          B_RSV      = 10;
    localparam int          B_GP1      = 9;
    localparam int          B_GP0      = 8;
    localparam int          B_GAIN     = 2;
    localparam logic [5:0]  CNT_FRAME  = 6'h18;
endpackage : dcr_pkg

/* core/dcr_frame_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dcr_frame_if;
    logic                            valid;
    logic [dcr_pkg::FRAME_BITS-1:0] word;
    logic [15:0]                     rd_data;
    modport rx   (output valid, output word, input rd_data);
    modport core (input valid, input word, output rd_data);
endinterface : dcr_frame_if
`default_nettype wire

/* core/dcr_spi_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module dcr_spi_rx
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic srst,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic sdi,
    output logic      sdo,
    dcr_frame_if.rx   frm
);
    import dcr_pkg::*;

    typedef enum logic {SP_IDLE, SP_SHIFT} dcr_sp_t;

    // pins sampled on mclk; sclk must stay well below mclk/8
    logic [2:0]            sy1_r, sy2_r, prv_r;
    dcr_sp_t               st_r, st_nxt;
    logic [5:0]            cnt_r, cnt_nxt;
    logic [FRAME_BITS-1:0] rx_r, rx_nxt, tx_r, tx_nxt, wd_r, wd_nxt;
    logic                  vld_r, vld_nxt;
    logic                  s_rise, s_fall, c_fall, c_rise;

    always_comb begin
        s_rise  = sy2_r[0] & ~prv_r[0];
        s_fall  = ~sy2_r[0] & prv_r[0];
        c_fall  = ~sy2_r[1] & prv_r[1];
        c_rise  = sy2_r[1] & ~prv_r[1];
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        rx_nxt  = rx_r;
        tx_nxt  = tx_r;
        wd_nxt  = wd_r;
        vld_nxt = 1'b0;
        case (st_r)
            SP_IDLE: begin
                if (c_fall) begin
                    st_nxt  = SP_SHIFT;
                    cnt_nxt = 6'h00;
                    tx_nxt  = {8'h00, frm.rd_data};
                end
            end
            SP_SHIFT: begin
                if (s_rise) begin
                    rx_nxt = {rx_r[FRAME_BITS-2:0], sy2_r[2]};
                    if (cnt_r != 6'h3f)
                        cnt_nxt = cnt_r + 6'h01;
                end
                if (s_fall)
                    tx_nxt = {tx_r[FRAME_BITS-2:0], 1'b0};
                if (c_rise) begin
                    // only whole frames are acted on
                    st_nxt  = SP_IDLE;
                    vld_nxt = (cnt_r == CNT_FRAME);
                    wd_nxt  = rx_r;
                end
            end
            default: st_nxt = SP_IDLE;
        endcase
        if (srst) begin
            st_nxt  = SP_IDLE;
            rx_nxt  = '0;
            tx_nxt  = '0;
            vld_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // idle levels, so no false sclk edge follows reset
            sy1_r <= 3'h2;
            sy2_r <= 3'h2;
            prv_r <= 3'h2;
            st_r  <= SP_IDLE;
            cnt_r <= 6'h00;
            rx_r  <= '0;
            tx_r  <= '0;
            wd_r  <= '0;
            vld_r <= 1'b0;
        end else begin
            sy1_r <= {sdi, cs_n, sclk};
            sy2_r <= sy1_r;
            prv_r <= sy2_r;
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            rx_r  <= rx_nxt;
            tx_r  <= tx_nxt;
            wd_r  <= wd_nxt;
            vld_r <= vld_nxt;
        end
    end

    assign frm.valid = vld_r;
    assign frm.word  = wd_r;
    assign sdo       = tx_r[FRAME_BITS-1];

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_frame_len;
        vld_r |-> $past(cnt_r) == CNT_FRAME && $past(st_r) == SP_SHIFT;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("short frame accepted");
endmodule : dcr_spi_rx
`default_nettype wire

/* core/dcr_chan_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module dcr_chan_bank #(
    parameter int NCH = 4,
    parameter int DW  = 14
) (
    input  wire logic                           mclk,
    input  wire logic                           rst,
    input  wire logic                           srst,
    input  wire logic                           wr_en,
    input  wire logic [$clog2(NCH)-1:0]         wr_ch,
    input  wire logic [DW-1:0]                  wr_data,
    input  wire logic                           load,
    output logic      [NCH-1:0][DW-1:0]         in_data,
    output logic      [NCH-1:0][DW-1:0]         latch
);
    logic [NCH-1:0][DW-1:0] in_r, in_nxt, lat_r, lat_nxt;
    logic [NCH-1:0]         dty_r, dty_nxt;

    always_comb begin
        in_nxt  = in_r;
        lat_nxt = lat_r;
        dty_nxt = dty_r;
        if (load) begin
            // untouched channels keep their latch, avoiding a glitch
            for (int i = 0; i < NCH; i++) begin
                if (dty_r[i]) begin
                    lat_nxt[i] = in_r[i];
                    dty_nxt[i] = 1'b0;
                end
            end
        end
        // a write in the load cycle stays pending for the next load
        if (wr_en) begin
            in_nxt[wr_ch]  = wr_data;
            dty_nxt[wr_ch] = 1'b1;
        end
        if (srst) begin
            in_nxt  = '0;
            lat_nxt = '0;
            dty_nxt = '0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_r  <= '0;
            lat_r <= '0;
            dty_r <= '0;
        end else begin
            in_r  <= in_nxt;
            lat_r <= lat_nxt;
            dty_r <= dty_nxt;
        end
    end

    assign in_data = in_r;
    assign latch   = lat_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_load_all;
        (load && !srst && dty_r[0] && dty_r[2]) |=>
            lat_r[0] == $past(in_r[0]) && lat_r[2] == $past(in_r[2]);
    endproperty
    a_load_all: assert property (p_load_all) else $error("latches not updated together");

    property p_load_dirty;
        (load && !srst && !dty_r[0]) |=> lat_r[0] == $past(lat_r[0]);
    endproperty
    a_load_dirty: assert property (p_load_dirty) else $error("clean latch reloaded");
    c_load: cover property (load && dty_r[0] && !dty_r[1]);
endmodule : dcr_chan_bank
`default_nettype wire

/* core/dcr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dcr_top
(
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    input  wire logic                          sdi,
    output logic                               sdo,
    input  wire logic                          load_pin_n,
    input  wire logic                          gpio0_in,
    output logic                               gpio0_out,
    output logic                               gpio0_oe_n,
    input  wire logic                          gpio1_in,
    output logic                               gpio1_out,
    output logic                               gpio1_oe_n,
    output logic                               group_a_powerdown,
    output logic                               group_b_powerdown,
    output logic [3:0]                         gain_sel,
    output logic [dcr_pkg::NCH-1:0][dcr_pkg::DW-1:0] channel_latch
);
    import dcr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // declarations

    dcr_frame_if frm ();

    logic [2:0]             sy1_r, sy2_r;
    logic                   ab_r, ab_nxt;
    logic                   ld_r, ld_nxt;
    logic                   pda_r, pda_nxt;
    logic                   pdb_r, pdb_nxt;
    logic                   gp1_r, gp1_nxt;
    logic                   gp0_r, gp0_nxt;
    logic [3:0]             gain_r, gain_nxt;
    logic                   srst_r, srst_nxt;
    logic [3:0]             rda_r, rda_nxt;
    logic [1:0]             drv_r, drv_nxt;
    logic                   ldp_s, gp0_s, gp1_s;
    logic                   wr, rd, wr_cmd, wr_dat, load;
    logic [3:0]             addr;
    logic [15:0]            d;
    logic [15:0]            rdw;
    logic [NCH-1:0][DW-1:0] in_data, latch;

    function automatic logic is_data(input logic [3:0] a);
        return a[3:2] == ADDR_DGRP;
    endfunction : is_data

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sy1_r <= 3'h7;
            sy2_r <= 3'h7;
        end else begin
            sy1_r <= {gpio1_in, gpio0_in, load_pin_n};
            sy2_r <= sy1_r;
        end
    end

    assign ldp_s = sy2_r[0];
    assign gp0_s = sy2_r[1];
    assign gp1_s = sy2_r[2];

    ////////////////////////////////////////////////////////////////////
    // serial frames and channel storage

    // power-down bits gate nothing here, so access never stops
    dcr_spi_rx u_rx (
        .mclk (mclk),
        .rst  (rst),
        .srst (srst_r),
        .sclk (sclk),
        .cs_n (cs_n),
        .sdi  (sdi),
        .sdo  (sdo),
        .frm  (frm.rx)
    );

    dcr_chan_bank #(
        .NCH (NCH),
        .DW  (DW)
    ) u_bank (
        .mclk    (mclk),
        .rst     (rst),
        .srst    (srst_r),
        .wr_en   (wr_dat),
        .wr_ch   (addr[1:0]),
        .wr_data (d[15:DATA_LO]),
        .load    (load),
        .in_data (in_data),
        .latch   (latch)
    );

    ////////////////////////////////////////////////////////////////////
    // command decode

    always_comb begin
        wr     = frm.valid & ~frm.word[RW_POS];
        rd     = frm.valid & frm.word[RW_POS];
        addr   = frm.word[ADDR_LO+3:ADDR_LO];
        d      = frm.word[15:0];
        wr_cmd = wr & (addr == ADDR_CMD);
        wr_dat = wr & is_data(addr) & ~srst_r;
        // a low pin loads every cycle, acting as a transparent latch
        load   = ld_r | ~ldp_s;
    end

    always_comb begin
        ab_nxt   = ab_r;
        ld_nxt   = 1'b0;
        pda_nxt  = pda_r;
        pdb_nxt  = pdb_r;
        gp1_nxt  = gp1_r;
        gp0_nxt  = gp0_r;
        gain_nxt = gain_r;
        srst_nxt = 1'b0;
        rda_nxt  = rda_r;
        drv_nxt  = 2'h0;
        if (wr_cmd) begin
            ab_nxt   = d[B_AB];
            ld_nxt   = d[B_LD] & ldp_s;
            pda_nxt  = d[B_PDA];
            pdb_nxt  = d[B_PDB];
            gp1_nxt  = d[B_GP1];
            gp0_nxt  = d[B_GP0];
            gain_nxt = d[B_GAIN+3:B_GAIN];
            srst_nxt = d[B_RST];
        end
        if (rd)
            rda_nxt = addr;
        if (srst_r) begin
            // soft reset takes the same values as the reset pin
            ab_nxt   = CMD_RST[B_AB];
            ld_nxt   = 1'b0;
            pda_nxt  = CMD_RST[B_PDA];
            pdb_nxt  = CMD_RST[B_PDB];
            gp1_nxt  = CMD_RST[B_GP1];
            gp0_nxt  = CMD_RST[B_GP0];
            gain_nxt = CMD_RST[B_GAIN+3:B_GAIN];
            srst_nxt = 1'b0;
            rda_nxt  = 4'h0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ab_r   <= CMD_RST[B_AB];
            ld_r   <= CMD_RST[B_LD];
            pda_r  <= CMD_RST[B_PDA];
            pdb_r  <= CMD_RST[B_PDB];
            gp1_r  <= CMD_RST[B_GP1];
            gp0_r  <= CMD_RST[B_GP0];
            gain_r <= CMD_RST[B_GAIN+3:B_GAIN];
            srst_r <= 1'b0;
            rda_r  <= 4'h0;
            drv_r  <= 2'h0;
        end else begin
            ab_r   <= ab_nxt;
            ld_r   <= ld_nxt;
            pda_r  <= pda_nxt;
            pdb_r  <= pdb_nxt;
            gp1_r  <= gp1_nxt;
            gp0_r  <= gp0_nxt;
            gain_r <= gain_nxt;
            srst_r <= srst_nxt;
            rda_r  <= rda_nxt;
            drv_r  <= drv_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // readback, sent during the frame after the read command

    always_comb begin
        rdw = 16'h0000;
        if (rda_r == ADDR_CMD) begin
            rdw[B_AB]                = ab_r;
            rdw[B_LD]                = ld_r;
            rdw[B_PDA]               = pda_r;
            rdw[B_PDB]               = pdb_r;
            rdw[B_GP1]               = gp1_s;
            rdw[B_GP0]               = gp0_s;
            rdw[B_GAIN+3:B_GAIN]     = gain_r;
        end else if (is_data(rda_r)) begin
            rdw[15:DATA_LO] = ab_r ? latch[rda_r[1:0]]
                                   : in_data[rda_r[1:0]];
        end
        // reserved, reset and unmapped bits stay zero
    end

    assign frm.rd_data = rdw;

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign gpio1_oe_n        = gp1_r;
    assign gpio0_oe_n        = gp0_r;
    assign gpio1_out         = drv_r[1];
    assign gpio0_out         = drv_r[0];
    assign group_a_powerdown = pda_r;
    assign group_b_powerdown = pdb_r;
    assign gain_sel          = gain_r;
    assign channel_latch     = latch;

    ////////////////////////////////////////////////////////////////////
    // assertions

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_ld_clear;
        ld_r |=> !ld_r;
    endproperty
    a_ld_clear: assert property (p_ld_clear) else $error("trigger stuck");

    property p_ld_ignored;
        (wr_cmd && d[B_LD] && !ldp_s) |=> !ld_r;
    endproperty
    a_ld_ignored: assert property (p_ld_ignored) else $error("trigger taken, pin low");

    property p_ld_taken;
        (wr_cmd && d[B_LD] && ldp_s && !srst_r) |=> ld_r ##1 !ld_r;
    endproperty
    a_ld_taken: assert property (p_ld_taken) else $error("trigger lost");

    property p_soft_rst;
        (wr_cmd && d[B_RST] && !srst_r) |=> srst_r ##1
            (!ab_r && !pda_r && !pdb_r && gp1_r && gp0_r && gain_r == 4'hf);
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset failed");

    property p_rsv_zero;
        rda_r == ADDR_CMD |-> !rdw[B_RSV] && !rdw[B_RST];
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");

    property p_gp_read;
        rda_r == ADDR_CMD |-> rdw[B_GP1] == sy2_r[2] && rdw[B_GP0] == sy2_r[1];
    endproperty
    a_gp_read: assert property (p_gp_read) else $error("pin level not read");

    property p_gp_open;
        !gpio0_out && !gpio1_out && (gpio0_oe_n == gp0_r);
    endproperty
    a_gp_open: assert property (p_gp_open) else $error("pin driven high");

    property p_pd_write;
        (wr_cmd && !srst_r) |=> pda_r == $past(d[B_PDA]) && pdb_r == $past(d[B_PDB]);
    endproperty
    a_pd_write: assert property (p_pd_write) else $error("power-down not written");

    property p_no_early;
        (!frm.valid && !srst_r) |=> $stable({ab_r, pda_r, pdb_r, gp1_r, gp0_r, gain_r});
    endproperty
    a_no_early: assert property (p_no_early) else $error("write outside frame end");

    property p_sel;
        (is_data(rda_r) && ab_r) |-> rdw[15:DATA_LO] == latch[rda_r[1:0]];
    endproperty
    a_sel: assert property (p_sel) else $error("wrong readback source");

    property p_rd_input;
        (is_data(rda_r) && !ab_r) |-> rdw[15:DATA_LO] == in_data[rda_r[1:0]];
    endproperty
    a_rd_input: assert property (p_rd_input) else $error("input register not read");

    property p_gp_drive;
        (wr_cmd && !srst_r) |=> gpio1_oe_n == $past(d[B_GP1]) && gpio0_oe_n == $past(d[B_GP0]);
    endproperty
    a_gp_drive: assert property (p_gp_drive) else $error("pin control not written");

    property p_rst_word;
        srst_r |=> gain_r == CMD_RST[B_GAIN+3:B_GAIN] && gp1_r == CMD_RST[B_GP1] && !ld_r;
    endproperty
    a_rst_word: assert property (p_rst_word) else $error("reset value wrong");

    property p_rst_lat;
        srst_r |=> channel_latch == '0 && !pda_r && !pdb_r;
    endproperty
    a_rst_lat: assert property (p_rst_lat) else $error("soft reset left state");

    c_ld: cover property (ld_r);
    c_srst: cover property (srst_r);
    c_rd_latch: cover property (is_data(rda_r) && ab_r);
    c_pin_load: cover property ($fell(ldp_s));
endmodule : dcr_top
`default_nettype wire

/* dv/dcr_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dcr_spi_host (
    input  wire logic mclk,
    input  wire logic sdo,
    output var logic  sclk,
    output var logic  cs_n,
    output var logic  sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////
    // msb first; nb below 24 makes a frame the device must refuse
    task automatic xfer(input logic [23:0] tx, input int nb,
                        output logic [23:0] rx);
        rx = 24'h0;
        @(negedge mclk);
        cs_n = 1'b0;
        repeat (6) @(negedge mclk);
        for (int i = 23; i > 23 - nb; i--) begin
            sdi = tx[i];
            repeat (5) @(negedge mclk);
            sclk = 1'b1;
            rx[i] = sdo;
            repeat (5) @(negedge mclk);
            sclk = 1'b0;
        end
        repeat (5) @(negedge mclk);
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        sdi = ~sdi;
        repeat (8) @(negedge mclk);
    endtask : xfer
endmodule : dcr_spi_host
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dcr_pkg::*;
    logic                    mclk;
    logic                    rst;
    logic                    sclk;
    logic                    cs_n;
    logic                    sdi;
    logic                    sdo;
    logic                    load_pin_n;
    logic                    ext0;
    logic                    ext1;
    logic                    gpio0_out;
    logic                    gpio0_oe_n;
    logic                    gpio1_out;
    logic                    gpio1_oe_n;
    logic                    group_a_powerdown;
    logic                    group_b_powerdown;
    logic [3:0]              gain_sel;
    logic [NCH-1:0][DW-1:0]  channel_latch;
    logic [23:0]             rx_q;
    int                      error_cnt = 0;
    int                      check_count = 0;
    wire logic               gpio0_in;
    wire logic               gpio1_in;
    // open-drain wire with external pull-up, ext pulls it low from outside
    assign gpio0_in = gpio0_oe_n ? ext0 : (gpio0_out & ext0);
    assign gpio1_in = gpio1_oe_n ? ext1 : (gpio1_out & ext1);
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;
    dcr_spi_host u_host (
        .mclk (mclk),
        .sdo  (sdo),
        .sclk (sclk),
        .cs_n (cs_n),
        .sdi  (sdi)
    );
    dcr_top u_dut (
        .mclk              (mclk),
        .rst               (rst),
        .sclk              (sclk),
        .cs_n              (cs_n),
        .sdi               (sdi),
        .sdo               (sdo),
        .load_pin_n        (load_pin_n),
        .gpio0_in          (gpio0_in),
        .gpio0_out         (gpio0_out),
        .gpio0_oe_n        (gpio0_oe_n),
        .gpio1_in          (gpio1_in),
        .gpio1_out         (gpio1_out),
        .gpio1_oe_n        (gpio1_oe_n),
        .group_a_powerdown (group_a_powerdown),
        .group_b_powerdown (group_b_powerdown),
        .gain_sel          (gain_sel),
        .channel_latch     (channel_latch)
    );
    //////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [23:0] rx;
        u_host.xfer({4'h0, a, d}, 24, rx);
    endtask : wr
    // second frame reads an unmapped place so nothing is disturbed
    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        logic [23:0] rx;
        u_host.xfer({4'h8, a, 16'h0}, 24, rx);
        u_host.xfer({4'h8, 4'h2, 16'h0}, 24, rx);
        chk("rd_hi", 16'h0000, {8'h00, rx[23:16]});
        chk("rd", exp, rx[15:0]);
    endtask : rdc
    task automatic chk_pins(input logic [15:0] pd, input logic [15:0] gp);
        chk("pd", pd, {14'h0, group_a_powerdown, group_b_powerdown});
        chk("gpio", gp, {12'h0, gpio1_oe_n, gpio0_oe_n, gpio1_out, gpio0_out});
    endtask : chk_pins
    task automatic chk_lat(input logic [15:0] l0, input logic [15:0] l1,
                           input logic [15:0] l2, input logic [15:0] l3);
        chk("latch0", l0, {2'b00, channel_latch[0]});
        chk("latch1", l1, {2'b00, channel_latch[1]});
        chk("latch2", l2, {2'b00, channel_latch[2]});
        chk("latch3", l3, {2'b00, channel_latch[3]});
    endtask : chk_lat
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    //////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        load_pin_n = 1'b1;
        ext0 = 1'b1;
        ext1 = 1'b1;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        rdc(4'h0, 16'h033c);
        chk("gain", 16'h000f, {12'h0, gain_sel});
        chk_pins(16'h0000, 16'h000c);
        wr(4'h0, 16'h9d14);
        chk_pins(16'h0003, 16'h0004);
        chk("gain", 16'h0005, {12'h0, gain_sel});
        rdc(4'h0, 16'h9914);
        @(negedge mclk);
        ext0 = 1'b0;
        rdc(4'h0, 16'h9814);
        @(negedge mclk);
        ext0 = 1'b1;
        wr(4'h0, 16'h0e3c);
        chk_pins(16'h0001, 16'h0008);
        rdc(4'h0, 16'h0a3c);
        // data path, only written channels may reload
        wr(4'h4, 16'h6af0);
        wr(4'h6, 16'h048c);
        chk_lat(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        wr(4'h0, 16'h433c);
        chk_lat(16'h1abc, 16'h0000, 16'h0123, 16'h0000);
        rdc(4'h0, 16'h033c);
        wr(4'h5, 16'haaa8);
        wr(4'h0, 16'h433c);
        chk_lat(16'h1abc, 16'h2aaa, 16'h0123, 16'h0000);
        wr(4'h4, 16'h1554);
        rdc(4'h4, 16'h1554);
        wr(4'h0, 16'h833c);
        rdc(4'h4, 16'h6af0);
        rdc(4'h0, 16'h833c);
        chk_lat(16'h1abc, 16'h2aaa, 16'h0123, 16'h0000);
        @(negedge mclk);
        load_pin_n = 1'b0;
        wr(4'h0, 16'h433c);
        rdc(4'h0, 16'h033c);
        chk_lat(16'h0555, 16'h2aaa, 16'h0123, 16'h0000);
        @(negedge mclk);
        load_pin_n = 1'b1;
        // refused frames and unmapped writes leave everything alone, soft reset clears
        u_host.xfer({8'h00, 16'h1b3c}, 23, rx_q);
        chk_pins(16'h0000, 16'h000c);
        wr(4'h2, 16'hffff);
        rdc(4'h2, 16'h0000);
        rdc(4'h0, 16'h033c);
        wr(4'h0, 16'h3b3c);
        chk_lat(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        chk_pins(16'h0000, 16'h000c);
        rdc(4'h0, 16'h033c);
        rdc(4'h4, 16'h0000);
        // hardware reset in mid-run must land in the same state
        wr(4'h4, 16'h1554);
        wr(4'h0, 16'h5d14);
        chk_lat(16'h0555, 16'h0000, 16'h0000, 16'h0000);
        chk_pins(16'h0003, 16'h0004);
        @(negedge mclk);
        rst = 1'b1;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        chk_pins(16'h0000, 16'h000c);
        chk_lat(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        rdc(4'h0, 16'h033c);
        rdc(4'h4, 16'h0000);
        test_done();
    end
    // tests need about 0.25 ms, so a hang is cut off at 1 ms
    initial begin
        #1000000;
        error_cnt++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
